//--- shared/sscl_pkg.sv
package sscl_pkg;
  localparam int ADDR_W = 12;
  localparam int BANK_BIT = 11;
  localparam int AP_BIT = 10;
  localparam int ROW_W = 11;
  localparam int COL_W = 8;
  localparam int TIMER_W = 9;
  localparam int CLK_PERIOD_NS = 10;
  localparam int ROW_TO_COLUMN_DELAY_NS = 20;
  localparam int ROW_PRECHARGE_TIME_NS = 20;
  localparam int MIN_ROW_ACTIVE_TIME_NS = 42;
  localparam int BANK_TO_BANK_ACTIVATE_DELAY_NS = 14;
  localparam int MODE_SET_DELAY_NS = 20;
  localparam int DATA_IN_TO_AUTOPRECHARGE_DELAY_NS = 30;
  // Least times, so each count rounds up
  localparam logic [TIMER_W-1:0] RCD_CYC =
    TIMER_W'((ROW_TO_COLUMN_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [TIMER_W-1:0] RP_CYC =
    TIMER_W'((ROW_PRECHARGE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [TIMER_W-1:0] RAS_CYC =
    TIMER_W'((MIN_ROW_ACTIVE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [TIMER_W-1:0] RRD_CYC =
    TIMER_W'((BANK_TO_BANK_ACTIVATE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [TIMER_W-1:0] MCD_CYC =
    TIMER_W'((MODE_SET_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [TIMER_W-1:0] DAL_CYC =
    TIMER_W'((DATA_IN_TO_AUTOPRECHARGE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int BL_LSB = 0;
  localparam int BL_MSB = 2;
  localparam logic [2:0] BL_FULL_PAGE = 3'h7;
  localparam logic [TIMER_W-1:0] FULL_PAGE_LEN = 9'h100;
  localparam logic [ADDR_W-1:0] MODE_RESET = 12'h000;

  typedef enum logic [3:0] {
    deselect_cmd, nop_cmd, burst_stop_cmd, read_cmd, read_autoprecharge_cmd,
    write_cmd, write_autoprecharge_cmd, activate_cmd, precharge_cmd,
    precharge_all_cmd, refresh_cmd, mode_register_set_cmd
  } sscl_cmd_type;

  typedef enum logic [2:0] {
    bank_idle, bank_activating, bank_active, bank_read_burst_ap,
    bank_write_burst_ap, bank_write_recovery_ap, bank_precharging
  } sscl_bank_state_type;

  typedef enum logic [2:0] {
    dev_normal, dev_refreshing, dev_mode_setting, dev_power_down, dev_self_refresh
  } sscl_dev_state_type;
endpackage

//--- shared/sscl_cmd_if.sv
`timescale 1ns/100ps
interface sscl_cmd_if;
  sscl_pkg::sscl_cmd_type cmd;
  logic bank;
  logic [sscl_pkg::COL_W-1:0] col;
  logic [sscl_pkg::ADDR_W-1:0] opcode;
  logic cke_now;
  logic cke_prev;
  modport decoder (output cmd, bank, col, opcode, cke_now, cke_prev);
  modport core (input cmd, bank, col, opcode, cke_now, cke_prev);
endinterface

//--- rtl/sscl_cmd_decode.sv
`timescale 1ns/100ps
module sscl_cmd_decode
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic cke,
  input wire logic [sscl_pkg::ADDR_W-1:0] addr,
  sscl_cmd_if.decoder cmd_if
);
  logic cs_n_q;
  logic ras_n_q;
  logic cas_n_q;
  logic we_n_q;
  logic cke_q;
  logic cke_qq;
  logic [sscl_pkg::ADDR_W-1:0] addr_q;

  // Pins share the controller clock, so one capture stage is enough
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cs_n_q <= 1'b1;
      ras_n_q <= 1'b1;
      cas_n_q <= 1'b1;
      we_n_q <= 1'b1;
      cke_q <= 1'b0;
      cke_qq <= 1'b0;
      addr_q <= '0;
    end
    else
    begin
      cs_n_q <= cs_n;
      ras_n_q <= ras_n;
      cas_n_q <= cas_n;
      we_n_q <= we_n;
      cke_q <= cke;
      cke_qq <= cke_q;
      addr_q <= addr;
    end
  end

  always_comb
  begin
    logic ap;
    ap = addr_q[sscl_pkg::AP_BIT];
    cmd_if.cmd = sscl_pkg::deselect_cmd;
    if (!cs_n_q)
    begin
      case ({ras_n_q, cas_n_q, we_n_q})
        3'h7: cmd_if.cmd = sscl_pkg::nop_cmd;
        3'h6: cmd_if.cmd = sscl_pkg::burst_stop_cmd;
        3'h5: cmd_if.cmd = ap ? sscl_pkg::read_autoprecharge_cmd : sscl_pkg::read_cmd;
        3'h4: cmd_if.cmd = ap ? sscl_pkg::write_autoprecharge_cmd : sscl_pkg::write_cmd;
        3'h3: cmd_if.cmd = sscl_pkg::activate_cmd;
        3'h2: cmd_if.cmd = ap ? sscl_pkg::precharge_all_cmd : sscl_pkg::precharge_cmd;
        3'h1: cmd_if.cmd = sscl_pkg::refresh_cmd;
        default: cmd_if.cmd = sscl_pkg::mode_register_set_cmd;
      endcase
    end
  end

  assign cmd_if.bank = addr_q[sscl_pkg::BANK_BIT];
  assign cmd_if.col = addr_q[sscl_pkg::COL_W-1:0];
  assign cmd_if.opcode = addr_q;
  assign cmd_if.cke_now = cke_q;
  assign cmd_if.cke_prev = cke_qq;
endmodule // sscl_cmd_decode

//--- rtl/sscl_command_legality.sv
`timescale 1ns/100ps
module sscl_command_legality
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic cke,
  input wire logic [sscl_pkg::ADDR_W-1:0] addr,
  output sscl_pkg::sscl_bank_state_type bank0_state,
  output sscl_pkg::sscl_bank_state_type bank1_state,
  output sscl_pkg::sscl_dev_state_type dev_state,
  output logic [sscl_pkg::ADDR_W-1:0] mode_reg,
  output logic [sscl_pkg::ROW_W-1:0] refresh_row,
  output logic illegal_cmd,
  output logic cmd_taken
);
  sscl_cmd_if cmd_if ();
  sscl_pkg::sscl_bank_state_type bank_state [2];
  logic [sscl_pkg::TIMER_W-1:0] bank_timer [2];
  logic [sscl_pkg::TIMER_W-1:0] ras_timer [2];
  logic [sscl_pkg::TIMER_W-1:0] dev_timer;
  logic [sscl_pkg::TIMER_W-1:0] rrd_timer;
  logic [sscl_pkg::TIMER_W-1:0] burst_len;
  logic both_idle;
  logic running;
  logic entering_low_power;
  logic legal;
  logic take;
  logic quiet_cmd;
  sscl_pkg::sscl_bank_state_type tgt_state;

  sscl_cmd_decode u_decode
  (
    .clk(clk),
    .rst_n(rst_n),
    .cs_n(cs_n),
    .ras_n(ras_n),
    .cas_n(cas_n),
    .we_n(we_n),
    .cke(cke),
    .addr(addr),
    .cmd_if(cmd_if)
  );

  always_comb
  begin
    case (mode_reg[sscl_pkg::BL_MSB:sscl_pkg::BL_LSB])
      3'h0: burst_len = 9'h001;
      3'h1: burst_len = 9'h002;
      3'h2: burst_len = 9'h004;
      3'h3: burst_len = 9'h008;
      default: burst_len = sscl_pkg::FULL_PAGE_LEN;
    endcase
  end

  assign both_idle = (bank_state[0] == sscl_pkg::bank_idle) &&
                     (bank_state[1] == sscl_pkg::bank_idle);
  // Low clock enable on the previous edge suspends the clock for this cycle
  assign running = (dev_state == sscl_pkg::dev_normal) && cmd_if.cke_prev;
  assign entering_low_power = running && !cmd_if.cke_now && both_idle;
  assign tgt_state = bank_state[cmd_if.bank];
  assign quiet_cmd = (cmd_if.cmd == sscl_pkg::deselect_cmd) ||
                     (cmd_if.cmd == sscl_pkg::nop_cmd) ||
                     (cmd_if.cmd == sscl_pkg::burst_stop_cmd);

  always_comb
  begin
    legal = 1'b1;
    case (cmd_if.cmd)
      sscl_pkg::burst_stop_cmd:
        legal = (mode_reg[sscl_pkg::BL_MSB:sscl_pkg::BL_LSB] == sscl_pkg::BL_FULL_PAGE);
      sscl_pkg::read_cmd, sscl_pkg::read_autoprecharge_cmd,
      sscl_pkg::write_cmd, sscl_pkg::write_autoprecharge_cmd:
        legal = (tgt_state == sscl_pkg::bank_active);
      sscl_pkg::activate_cmd:
        legal = (tgt_state == sscl_pkg::bank_idle) && (rrd_timer == '0);
      sscl_pkg::precharge_cmd:
        legal = (tgt_state == sscl_pkg::bank_idle) ||
                ((tgt_state == sscl_pkg::bank_active) && (ras_timer[cmd_if.bank] == '0));
      sscl_pkg::precharge_all_cmd:
        legal = ((bank_state[0] == sscl_pkg::bank_idle) ||
                 ((bank_state[0] == sscl_pkg::bank_active) && (ras_timer[0] == '0))) &&
                ((bank_state[1] == sscl_pkg::bank_idle) ||
                 ((bank_state[1] == sscl_pkg::bank_active) && (ras_timer[1] == '0)));
      sscl_pkg::refresh_cmd, sscl_pkg::mode_register_set_cmd:
        legal = both_idle;
      default:
        legal = 1'b1;
    endcase
  end

  assign take = running && !entering_low_power && legal && !quiet_cmd;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      illegal_cmd <= 1'b0;
      cmd_taken <= 1'b0;
    end
    else
    begin
      cmd_taken <= take;
      // Power-down and self-refresh flag nothing: the pins are ignored there
      if (running && !entering_low_power)
        illegal_cmd <= !legal;
      else if ((dev_state == sscl_pkg::dev_refreshing) ||
               (dev_state == sscl_pkg::dev_mode_setting))
        illegal_cmd <= !quiet_cmd;
      else
        illegal_cmd <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dev_state <= sscl_pkg::dev_normal;
      dev_timer <= '0;
    end
    else
    begin
      case (dev_state)
        sscl_pkg::dev_normal:
        begin
          if (entering_low_power)
            dev_state <= (cmd_if.cmd == sscl_pkg::refresh_cmd) ?
                         sscl_pkg::dev_self_refresh : sscl_pkg::dev_power_down;
          else if (take && (cmd_if.cmd == sscl_pkg::refresh_cmd))
          begin
            dev_state <= sscl_pkg::dev_refreshing;
            dev_timer <= sscl_pkg::RP_CYC;
          end
          else if (take && (cmd_if.cmd == sscl_pkg::mode_register_set_cmd))
          begin
            dev_state <= sscl_pkg::dev_mode_setting;
            dev_timer <= sscl_pkg::MCD_CYC;
          end
        end
        sscl_pkg::dev_refreshing, sscl_pkg::dev_mode_setting:
        begin
          if (dev_timer <= 9'h001)
            dev_state <= sscl_pkg::dev_normal;
          else
            dev_timer <= dev_timer - 9'h001;
        end
        sscl_pkg::dev_power_down, sscl_pkg::dev_self_refresh:
        begin
          if (!cmd_if.cke_prev && cmd_if.cke_now)
            dev_state <= sscl_pkg::dev_normal;
        end
        default:
          dev_state <= sscl_pkg::dev_normal;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      mode_reg <= sscl_pkg::MODE_RESET;
    else if (take && (cmd_if.cmd == sscl_pkg::mode_register_set_cmd))
      mode_reg <= cmd_if.opcode;
  end

  // The row counter advances on its own; address pins never reach it
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      refresh_row <= '0;
    else if (take && (cmd_if.cmd == sscl_pkg::refresh_cmd))
      refresh_row <= refresh_row + 11'h001;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rrd_timer <= '0;
    else if (take && (cmd_if.cmd == sscl_pkg::activate_cmd))
      rrd_timer <= sscl_pkg::RRD_CYC - 9'h001;
    else if (rrd_timer != '0)
      rrd_timer <= rrd_timer - 9'h001;
  end

  for (genvar b = 0; b < 2; b++)
  begin : g_bank
    logic hit;
    assign hit = take && ((cmd_if.bank == 1'(b)) ||
                          (cmd_if.cmd == sscl_pkg::precharge_all_cmd));

    always_ff @(posedge clk or negedge rst_n)
    begin
      if (!rst_n)
        ras_timer[b] <= '0;
      else if (hit && (cmd_if.cmd == sscl_pkg::activate_cmd))
        ras_timer[b] <= sscl_pkg::RAS_CYC - 9'h001;
      else if (ras_timer[b] != '0)
        ras_timer[b] <= ras_timer[b] - 9'h001;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
      if (!rst_n)
      begin
        bank_state[b] <= sscl_pkg::bank_idle;
        bank_timer[b] <= '0;
      end
      else if (running)
      begin
        case (bank_state[b])
          sscl_pkg::bank_idle:
          begin
            if (hit && (cmd_if.cmd == sscl_pkg::activate_cmd))
            begin
              bank_state[b] <= sscl_pkg::bank_activating;
              bank_timer[b] <= sscl_pkg::RCD_CYC;
            end
          end
          sscl_pkg::bank_activating:
          begin
            if (bank_timer[b] <= 9'h001)
              bank_state[b] <= sscl_pkg::bank_active;
            else
              bank_timer[b] <= bank_timer[b] - 9'h001;
          end
          sscl_pkg::bank_active:
          begin
            if (hit && (cmd_if.cmd == sscl_pkg::read_autoprecharge_cmd))
            begin
              bank_state[b] <= sscl_pkg::bank_read_burst_ap;
              bank_timer[b] <= burst_len;
            end
            else if (hit && (cmd_if.cmd == sscl_pkg::write_autoprecharge_cmd))
            begin
              bank_state[b] <= sscl_pkg::bank_write_burst_ap;
              bank_timer[b] <= burst_len;
            end
            else if (hit && ((cmd_if.cmd == sscl_pkg::precharge_cmd) ||
                             (cmd_if.cmd == sscl_pkg::precharge_all_cmd)))
            begin
              bank_state[b] <= sscl_pkg::bank_precharging;
              bank_timer[b] <= sscl_pkg::RP_CYC;
            end
          end
          sscl_pkg::bank_read_burst_ap:
          begin
            if (bank_timer[b] <= 9'h001)
            begin
              bank_state[b] <= sscl_pkg::bank_precharging;
              bank_timer[b] <= sscl_pkg::RP_CYC;
            end
            else
              bank_timer[b] <= bank_timer[b] - 9'h001;
          end
          sscl_pkg::bank_write_burst_ap:
          begin
            if (bank_timer[b] <= 9'h001)
            begin
              bank_state[b] <= sscl_pkg::bank_write_recovery_ap;
              bank_timer[b] <= sscl_pkg::DAL_CYC;
            end
            else
              bank_timer[b] <= bank_timer[b] - 9'h001;
          end
          sscl_pkg::bank_write_recovery_ap, sscl_pkg::bank_precharging:
          begin
            if (bank_timer[b] <= 9'h001)
              bank_state[b] <= sscl_pkg::bank_idle;
            else
              bank_timer[b] <= bank_timer[b] - 9'h001;
          end
          default:
            bank_state[b] <= sscl_pkg::bank_idle;
        endcase
      end
    end
  end

  assign bank0_state = bank_state[0];
  assign bank1_state = bank_state[1];
endmodule // sscl_command_legality

//--- dv/sscl_ctrl_model.sv
`timescale 1ns/100ps
module sscl_ctrl_model
(
  input sscl_pkg::sscl_cmd_type req_cmd,
  input wire logic [sscl_pkg::ADDR_W-1:0] req_addr,
  output logic [3:0] pins,
  output logic [sscl_pkg::ADDR_W-1:0] addr
);
  // Pins are {cs_n, ras_n, cas_n, we_n}
  // Deselected address shows the inverse of the last one, so a stale copy never passes
  always_comb
  begin
    addr = req_addr;
    pins = 4'hF;
    case (req_cmd)
      sscl_pkg::deselect_cmd: addr = ~req_addr;
      sscl_pkg::nop_cmd: pins = 4'h7;
      sscl_pkg::burst_stop_cmd: pins = 4'h6;
      sscl_pkg::read_cmd, sscl_pkg::read_autoprecharge_cmd: pins = 4'h5;
      sscl_pkg::write_cmd, sscl_pkg::write_autoprecharge_cmd: pins = 4'h4;
      sscl_pkg::activate_cmd: pins = 4'h3;
      sscl_pkg::precharge_cmd, sscl_pkg::precharge_all_cmd: pins = 4'h2;
      sscl_pkg::refresh_cmd: pins = 4'h1;
      sscl_pkg::mode_register_set_cmd: pins = 4'h0;
      default: pins = 4'h7;
    endcase
    // A10 picks the auto-precharge or all-bank form, so plain forms must hold it low
    if ((req_cmd == sscl_pkg::write_autoprecharge_cmd) ||
        (req_cmd == sscl_pkg::read_autoprecharge_cmd) ||
        (req_cmd == sscl_pkg::precharge_all_cmd))
      addr[sscl_pkg::AP_BIT] = 1'b1;
    else if ((req_cmd == sscl_pkg::read_cmd) || (req_cmd == sscl_pkg::write_cmd) ||
             (req_cmd == sscl_pkg::precharge_cmd))
      addr[sscl_pkg::AP_BIT] = 1'b0;
  end
endmodule // sscl_ctrl_model

//--- dv/sscl_command_legality_sva.sv
`timescale 1ns/100ps
module sscl_command_legality_sva
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic cke,
  input wire logic [sscl_pkg::ADDR_W-1:0] addr,
  input sscl_pkg::sscl_bank_state_type bank0_state,
  input sscl_pkg::sscl_bank_state_type bank1_state,
  input sscl_pkg::sscl_dev_state_type dev_state,
  input wire logic [sscl_pkg::ADDR_W-1:0] mode_reg,
  input wire logic [sscl_pkg::ROW_W-1:0] refresh_row,
  input wire logic illegal_cmd,
  input wire logic cmd_taken
);
  localparam sscl_pkg::sscl_dev_state_type DN = sscl_pkg::dev_normal,
    DR = sscl_pkg::dev_refreshing, DM = sscl_pkg::dev_mode_setting,
    DP = sscl_pkg::dev_power_down, DS = sscl_pkg::dev_self_refresh;
  localparam sscl_pkg::sscl_bank_state_type BI = sscl_pkg::bank_idle,
    BG = sscl_pkg::bank_activating, BA = sscl_pkg::bank_active,
    BR = sscl_pkg::bank_write_recovery_ap;
  wire calm_pins = cs_n | (ras_n & cas_n & we_n);
  wire busy_pins = ~cs_n & ~(ras_n & cas_n);
  wire mrs_pins = ~cs_n & ~ras_n & ~cas_n & ~we_n;
  wire rest = dev_state == DN && bank0_state == BI && bank1_state == BI;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  sequence s_ref_run;
    (dev_state == DR) ##1 (dev_state == DN);
  endsequence
  sequence s_mode_run;
    (dev_state == DM) ##1 (dev_state == DN);
  endsequence
  sequence s_rec_run;
    (bank0_state == BR) [*2] ##1 (bank0_state == BI);
  endsequence
  sequence s_act_run;
    (bank0_state == BG) ##1 (bank0_state == BA);
  endsequence
  // Outputs land one edge after capture, so they are sampled two edges after the pins
  property p_mode_load;
    mrs_pins && cke && $past(cke) && rest |-> ##2 mode_reg == $past(addr, 2);
  endproperty
  a_mode_load: assert property (p_mode_load) else $error("mode load");
  property p_ref_row;
    dev_state == DR && $past(dev_state) != DR |-> refresh_row == $past(refresh_row) + 11'h001;
  endproperty
  a_ref_row: assert property (p_ref_row) else $error("refresh row");
  property p_ref_done;
    dev_state == DR && $past(dev_state) != DR |=> s_ref_run;
  endproperty
  a_ref_done: assert property (p_ref_done) else $error("refresh end");
  property p_mode_done;
    dev_state == DM && $past(dev_state) != DM |=> s_mode_run;
  endproperty
  a_mode_done: assert property (p_mode_done) else $error("mode end");
  property p_rec_done;
    bank0_state == BR && $past(bank0_state) != BR |=> s_rec_run;
  endproperty
  a_rec_done: assert property (p_rec_done) else $error("recovery end");
  property p_act_done;
    bank0_state == BG && $past(bank0_state) != BG |=> s_act_run;
  endproperty
  a_act_done: assert property (p_act_done) else $error("activate end");
  property p_busy_illegal;
    busy_pins && cke && $past(cke) ##1 (dev_state == DR || dev_state == DM) |=> illegal_cmd;
  endproperty
  a_busy_illegal: assert property (p_busy_illegal) else $error("busy flag");
  property p_calm;
    calm_pins |-> ##2 !illegal_cmd;
  endproperty
  a_calm: assert property (p_calm) else $error("quiet flagged");
  property p_sleep;
    (dev_state == DP || dev_state == DS) && !cke && !$past(cke) |-> ##2 !illegal_cmd && !cmd_taken;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep pins seen");
endmodule // sscl_command_legality_sva

bind sscl_command_legality sscl_command_legality_sva sscl_command_legality_sva_inst
(
  .clk(clk), .rst_n(rst_n), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
  .cke(cke), .addr(addr), .bank0_state(bank0_state), .bank1_state(bank1_state),
  .dev_state(dev_state), .mode_reg(mode_reg), .refresh_row(refresh_row),
  .illegal_cmd(illegal_cmd), .cmd_taken(cmd_taken)
);

//--- dv/sscl_command_legality_tb.sv
`timescale 1ns/100ps
`define CHK(nm, exp, got) begin n_tests++; if ((got) !== (exp)) begin num_errors++; \
  $display("unexpected %s: expected %0h seen %0h", nm, exp, got); end end
module sscl_command_legality_tb;
  localparam sscl_pkg::sscl_cmd_type C_DES = sscl_pkg::deselect_cmd,
    C_NOP = sscl_pkg::nop_cmd, C_STOP = sscl_pkg::burst_stop_cmd, C_RD = sscl_pkg::read_cmd,
    C_WR = sscl_pkg::write_cmd, C_WRAP = sscl_pkg::write_autoprecharge_cmd,
    C_OPEN = sscl_pkg::activate_cmd, C_SHUT = sscl_pkg::precharge_cmd,
    C_REF = sscl_pkg::refresh_cmd, C_MODE = sscl_pkg::mode_register_set_cmd,
    C_RDAP = sscl_pkg::read_autoprecharge_cmd, C_ALL = sscl_pkg::precharge_all_cmd;
  localparam sscl_pkg::sscl_bank_state_type BI = sscl_pkg::bank_idle,
    BG = sscl_pkg::bank_activating, BA = sscl_pkg::bank_active,
    BW = sscl_pkg::bank_write_burst_ap, BR = sscl_pkg::bank_write_recovery_ap,
    BP = sscl_pkg::bank_precharging, BQ = sscl_pkg::bank_read_burst_ap;
  localparam sscl_pkg::sscl_dev_state_type DN = sscl_pkg::dev_normal,
    DM = sscl_pkg::dev_mode_setting, DR = sscl_pkg::dev_refreshing;
  typedef struct {
    sscl_pkg::sscl_cmd_type c;
    logic [11:0] a;
    sscl_pkg::sscl_bank_state_type b0, b1;
    sscl_pkg::sscl_dev_state_type d;
    logic il, tk;
  } sscl_row_type;
  // Commands go out every second cycle; each row holds the state one edge after capture
  sscl_row_type rows [27] = '{
    '{C_MODE, 12'h007, BI, BI, DM, 1'h0, 1'h1},
    '{C_STOP, 12'h000, BI, BI, DN, 1'h0, 1'h0},
    '{C_MODE, 12'h000, BI, BI, DM, 1'h0, 1'h1},
    '{C_RD, 12'h000, BI, BI, DN, 1'h1, 1'h0},
    '{C_REF, 12'hFFF, BI, BI, DR, 1'h0, 1'h1},
    '{C_OPEN, 12'h000, BI, BI, DN, 1'h1, 1'h0},
    '{C_OPEN, 12'h000, BG, BI, DN, 1'h0, 1'h1},
    '{C_WR, 12'h000, BA, BI, DN, 1'h1, 1'h0},
    '{C_OPEN, 12'h800, BA, BG, DN, 1'h0, 1'h1},
    '{C_WRAP, 12'h300, BW, BA, DN, 1'h0, 1'h1},
    '{C_OPEN, 12'h000, BR, BA, DN, 1'h1, 1'h0},
    '{C_NOP, 12'h000, BI, BA, DN, 1'h0, 1'h0},
    '{C_STOP, 12'h000, BI, BA, DN, 1'h1, 1'h0},
    '{C_SHUT, 12'h800, BI, BP, DN, 1'h0, 1'h1},
    '{C_OPEN, 12'h000, BG, BI, DN, 1'h0, 1'h1},
    '{C_SHUT, 12'h000, BA, BI, DN, 1'h1, 1'h0},
    '{C_NOP, 12'h000, BA, BI, DN, 1'h0, 1'h0},
    '{C_SHUT, 12'h000, BP, BI, DN, 1'h0, 1'h1},
    '{C_NOP, 12'h000, BI, BI, DN, 1'h0, 1'h0},
    '{C_OPEN, 12'h000, BG, BI, DN, 1'h0, 1'h1},
    '{C_NOP, 12'h000, BA, BI, DN, 1'h0, 1'h0},
    '{C_RDAP, 12'h000, BQ, BI, DN, 1'h0, 1'h1},
    '{C_OPEN, 12'h800, BP, BG, DN, 1'h0, 1'h1},
    '{C_ALL, 12'h000, BI, BA, DN, 1'h1, 1'h0},
    '{C_ALL, 12'h000, BI, BA, DN, 1'h1, 1'h0},
    '{C_ALL, 12'h000, BI, BP, DN, 1'h0, 1'h1},
    '{C_NOP, 12'h000, BI, BI, DN, 1'h0, 1'h0}
  };
  logic clk = 1'b0;
  logic rst_n;
  logic cke;
  sscl_pkg::sscl_cmd_type req_cmd;
  logic [11:0] req_addr;
  logic [3:0] pins;
  logic [11:0] addr;
  sscl_pkg::sscl_bank_state_type bank0_state;
  sscl_pkg::sscl_bank_state_type bank1_state;
  sscl_pkg::sscl_dev_state_type dev_state;
  logic [11:0] mode_reg;
  logic [10:0] refresh_row;
  logic illegal_cmd;
  logic cmd_taken;
  int num_errors = 0;
  int n_tests = 0;
  always #5 clk = ~clk;
  sscl_ctrl_model sscl_ctrl_model_inst
  (
    .req_cmd(req_cmd), .req_addr(req_addr), .pins(pins), .addr(addr)
  );
  sscl_command_legality sscl_command_legality_inst
  (
    .clk(clk), .rst_n(rst_n), .cs_n(pins[3]), .ras_n(pins[2]), .cas_n(pins[1]),
    .we_n(pins[0]), .cke(cke), .addr(addr), .bank0_state(bank0_state),
    .bank1_state(bank1_state), .dev_state(dev_state), .mode_reg(mode_reg),
    .refresh_row(refresh_row), .illegal_cmd(illegal_cmd), .cmd_taken(cmd_taken)
  );
  task automatic complete_run;
    $display("checks %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic issue(input sscl_pkg::sscl_cmd_type c, input logic [11:0] a);
    req_cmd = c;
    req_addr = a;
    @(negedge clk);
    req_cmd = C_DES;
    @(negedge clk);
  endtask
  // About 90 cycles are needed; the margin covers a hung state machine
  initial
  begin
    #20000;
    num_errors++;
    complete_run;
  end
  initial
  begin
    rst_n = 1'b0;
    cke = 1'b1;
    req_cmd = C_DES;
    req_addr = 12'h000;
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    foreach (rows[i])
    begin
      issue(rows[i].c, rows[i].a);
      `CHK("bank0", rows[i].b0, bank0_state)
      `CHK("bank1", rows[i].b1, bank1_state)
      `CHK("state", rows[i].d, dev_state)
      `CHK("illegal", rows[i].il, illegal_cmd)
      `CHK("taken", rows[i].tk, cmd_taken)
    end
    `CHK("mode", 12'h000, mode_reg)
    `CHK("row", 11'h001, refresh_row)
    cke = 1'b0;
    repeat (3) @(negedge clk);
    `CHK("down", sscl_pkg::dev_power_down, dev_state)
    issue(C_OPEN, 12'h000);
    `CHK("bank0", BI, bank0_state)
    `CHK("illegal", 1'h0, illegal_cmd)
    cke = 1'b1;
    repeat (4) @(negedge clk);
    `CHK("state", DN, dev_state)
    req_cmd = C_REF;
    cke = 1'b0;
    @(negedge clk);
    req_cmd = C_DES;
    repeat (2) @(negedge clk);
    `CHK("self", sscl_pkg::dev_self_refresh, dev_state)
    issue(C_MODE, 12'h007);
    `CHK("mode", 12'h000, mode_reg)
    cke = 1'b1;
    repeat (4) @(negedge clk);
    `CHK("state", DN, dev_state)
    issue(C_MODE, 12'h007);
    `CHK("mode", 12'h007, mode_reg)
    @(negedge clk);
    issue(C_STOP, 12'h000);
    `CHK("illegal", 1'h0, illegal_cmd)
    `CHK("state", DN, dev_state)
    rst_n = 1'b0;
    #1;
    `CHK("reset mode", 12'h000, mode_reg)
    `CHK("reset state", DN, dev_state)
    repeat (4) @(negedge clk);
    complete_run;
  end
endmodule // sscl_command_legality_tb
